// ---- rtl/eag_adder.sv ----
// modulo 2^16 address adder
module eag_adder #(
  parameter int unsigned WIDTH = 16
) (
  input  wire logic [WIDTH-1:0] a,
  input  wire logic [WIDTH-1:0] b,
  output logic      [WIDTH-1:0] sum
);
  logic [WIDTH:0] full;
  always_comb begin
    full = {1'b0, a} + {1'b0, b};
    // carry out dropped on purpose
    sum  = full[WIDTH-1:0]; // RULE21
  end
endmodule

// ---- rtl/eag_pkg.sv ----
// package of effective address generator constants and carriers
package eag_pkg;
  localparam int unsigned ADDR_W      = 16;
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned WORD_BYTES  = 2;
  localparam int unsigned BIT_IDX_W   = 3;
  localparam int unsigned STR_MAX     = 65536;
  localparam int unsigned EPU_STR_MAX = 16;
  localparam int unsigned CNT_W       = 17;
  localparam int unsigned EPU_CNT_W   = 5;
  localparam logic [15:0] ADDR_RST    = 16'h0000;

  typedef enum logic [2:0] {
    EAG_LONG_INDEX,
    EAG_SHORT_INDEX,
    EAG_PC_REL,
    EAG_SP_REL,
    EAG_BASE_INDEX
  } eag_mode_type;

  typedef enum logic [1:0] {
    EAG_SEL_PAIR,
    EAG_SEL_FIRST,
    EAG_SEL_SECOND
  } eag_reg_sel_type;

  typedef enum logic [1:0] {
    EAG_SPACE_DATA,
    EAG_SPACE_PROG,
    EAG_SPACE_IO
  } eag_space_type;

  typedef enum logic [1:0] {
    EAG_OP_BYTE,
    EAG_OP_WORD,
    EAG_OP_BIT,
    EAG_OP_BCD
  } eag_optype_type;

  typedef enum logic [1:0] {
    EAG_BIT_TEST,
    EAG_BIT_SET,
    EAG_BIT_CLEAR
  } eag_bitop_type;

  typedef struct packed {
    logic            valid;
    eag_mode_type    mode;
    eag_reg_sel_type base_sel;
    eag_reg_sel_type index_sel;
    logic [15:0]     disp;
    logic            extended;
    logic            control;
    eag_optype_type  op_type;
    eag_bitop_type   bit_op;
    logic [2:0]      bit_num;
    logic            io_access;
    logic            io_word;
  } eag_req_type;

  typedef struct packed {
    logic [15:0] pointer_pair_register;
    logic [15:0] first_index_register;
    logic [15:0] second_index_register;
    logic [15:0] system_sp;
    logic [15:0] user_sp;
    logic [15:0] next_pc;
    logic [15:0] template_pc;
    logic        user_mode;
  } eag_regs_type;

  typedef struct packed {
    logic           valid;
    logic [15:0]    addr;
    logic [15:0]    addr_hi;
    eag_space_type  space;
    logic           word;
    logic [7:0]     bit_mask;
    eag_bitop_type  bit_op;
    logic           bcd;
  } eag_acc_type;
endpackage

// ---- rtl/eag_top.sv ----
// effective address generator datapath
// Behaviour
// RULE1 - long indexed: instruction address plus selected signed index register
// RULE2 - short indexed: one-byte displacement plus first or second index register
// RULE3 - short displacement sign-extended to sixteen bits before adding
// RULE4 - short indexed operands always in data memory space
// RULE5 - pc relative: signed displacement up to sixteen bits plus pc base
// RULE6 - ordinary instructions use address of next instruction as base
// RULE7 - extended instructions use template address as base
// RULE8 - pc relative operands always in program memory space
// RULE9 - relative control transfer loads sum into program counter
// RULE10 - stack relative: sixteen-bit displacement plus stack pointer, data space
// RULE11 - system or user stack pointer chosen by user/system bit
// RULE12 - base-plus-index: sum of two different registers of the three
// RULE13 - base-plus-index operands always in data memory space
// RULE14 - byte addressable; word occupies two consecutive bytes
// RULE15 - io transfers in byte or word width
// RULE16 - logical addresses sixteen bits wide
// RULE17 - bit operand selected by number within byte
// RULE18 - packed decimal: two digits per byte
// RULE19 - block strings up to 65536 bytes
// RULE20 - extended unit strings at most sixteen bytes
// RULE21 - address additions wrap modulo two to the sixteenth
module eag_top #(
  parameter int unsigned STR_MAX     = eag_pkg::STR_MAX,
  parameter int unsigned EPU_STR_MAX = eag_pkg::EPU_STR_MAX
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire eag_pkg::eag_req_type req,
  input  wire eag_pkg::eag_regs_type regs,
  input  wire logic [16:0]          str_len,
  input  wire logic                 str_epu,
  output eag_pkg::eag_acc_type      acc,
  output logic                      pc_load,
  output logic [15:0]               pc_target,
  output logic                      sel_error,
  output logic                      str_len_error
);
  logic [15:0]            base_v;
  logic [15:0]            off_v;
  logic [15:0]            sum_v;
  logic [15:0]            hi_v;
  logic                   bad_sel;
  eag_pkg::eag_space_type space_v;
  eag_pkg::eag_acc_type   acc_d;
  eag_pkg::eag_acc_type   acc_q;
  logic                   pc_load_d;
  logic                   pc_load_q;
  logic [15:0]            pc_target_d;
  logic [15:0]            pc_target_q;
  logic                   sel_err_d;
  logic                   sel_err_q;
  logic                   len_err_d;
  logic                   len_err_q;
  logic                   len_bad;

  function automatic logic [15:0] pick(input eag_pkg::eag_reg_sel_type s,
                                       input eag_pkg::eag_regs_type r);
    case (s)
      eag_pkg::EAG_SEL_PAIR:   pick = r.pointer_pair_register;
      eag_pkg::EAG_SEL_FIRST:  pick = r.first_index_register;
      eag_pkg::EAG_SEL_SECOND: pick = r.second_index_register;
      default:                 pick = 16'h0000;
    endcase
  endfunction

  always_comb begin
    base_v  = 16'h0000;
    off_v   = 16'h0000;
    bad_sel = 1'b0;
    space_v = eag_pkg::EAG_SPACE_DATA;
    case (req.mode)
      eag_pkg::EAG_LONG_INDEX: begin
        base_v = req.disp; // RULE1
        off_v  = pick(req.index_sel, regs); // RULE1
      end
      eag_pkg::EAG_SHORT_INDEX: begin
        base_v  = pick(req.index_sel, regs); // RULE2
        off_v   = {{8{req.disp[7]}}, req.disp[7:0]}; // RULE3
        bad_sel = (req.index_sel == eag_pkg::EAG_SEL_PAIR);
        space_v = eag_pkg::EAG_SPACE_DATA; // RULE4
      end
      eag_pkg::EAG_PC_REL: begin
        // template address differs from next pc only for extended ops
        base_v  = req.extended ? regs.template_pc : regs.next_pc; // RULE6 RULE7
        off_v   = req.disp; // RULE5
        space_v = eag_pkg::EAG_SPACE_PROG; // RULE8
      end
      eag_pkg::EAG_SP_REL: begin
        base_v  = regs.user_mode ? regs.user_sp : regs.system_sp; // RULE11
        off_v   = req.disp; // RULE10
        space_v = eag_pkg::EAG_SPACE_DATA; // RULE10
      end
      eag_pkg::EAG_BASE_INDEX: begin
        base_v  = pick(req.base_sel, regs); // RULE12
        off_v   = pick(req.index_sel, regs); // RULE12
        bad_sel = (req.base_sel == req.index_sel);
        space_v = eag_pkg::EAG_SPACE_DATA; // RULE13
      end
      default: begin
        bad_sel = 1'b1;
      end
    endcase
    if (req.io_access && req.mode == eag_pkg::EAG_LONG_INDEX) begin
      space_v = eag_pkg::EAG_SPACE_IO;
    end
  end

  eag_adder #(.WIDTH(eag_pkg::ADDR_W)) u_add (
    .a   (base_v),
    .b   (off_v),
    .sum (sum_v)
  );

  eag_adder #(.WIDTH(eag_pkg::ADDR_W)) u_hi (
    .a   (sum_v),
    .b   (16'h0001),
    .sum (hi_v)
  );

  // string limit depends on who moves it
  always_comb begin
    if (str_epu) begin
      len_bad = (str_len > 17'(EPU_STR_MAX)) || (str_len == 17'h00000); // RULE20
    end else begin
      len_bad = (str_len > 17'(STR_MAX)) || (str_len == 17'h00000); // RULE19
    end
  end

  always_comb begin
    acc_d       = '0;
    pc_load_d   = 1'b0;
    pc_target_d = pc_target_q;
    sel_err_d   = 1'b0;
    len_err_d   = len_bad;
    if (req.valid && !bad_sel) begin
      acc_d.valid  = !req.control;
      acc_d.addr   = sum_v; // RULE16
      acc_d.addr_hi = hi_v; // RULE14
      acc_d.space  = space_v;
      acc_d.word   = (req.op_type == eag_pkg::EAG_OP_WORD) ||
                     (req.io_access && req.io_word); // RULE14 RULE15
      acc_d.bit_mask = (req.op_type == eag_pkg::EAG_OP_BIT) ?
                       (8'h01 << req.bit_num) : 8'h00; // RULE17
      acc_d.bit_op = req.bit_op; // RULE17
      acc_d.bcd    = (req.op_type == eag_pkg::EAG_OP_BCD); // RULE18
      if (req.control && req.mode == eag_pkg::EAG_PC_REL) begin
        pc_load_d   = 1'b1; // RULE9
        pc_target_d = sum_v; // RULE9
      end
    end else if (req.valid) begin
      sel_err_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_q       <= '0;
      pc_load_q   <= 1'b0;
      pc_target_q <= eag_pkg::ADDR_RST;
      sel_err_q   <= 1'b0;
      len_err_q   <= 1'b0;
    end else begin
      acc_q       <= acc_d;
      pc_load_q   <= pc_load_d;
      pc_target_q <= pc_target_d;
      sel_err_q   <= sel_err_d;
      len_err_q   <= len_err_d;
    end
  end

  assign acc           = acc_q;
  assign pc_load       = pc_load_q;
  assign pc_target     = pc_target_q;
  assign sel_error     = sel_err_q;
  assign str_len_error = len_err_q;

  property p_short_sext;
    @(posedge sys_clk) disable iff (rst)
    (req.valid && req.mode == eag_pkg::EAG_SHORT_INDEX && req.disp[7:0] == 8'hff &&
     req.index_sel == eag_pkg::EAG_SEL_FIRST && !req.control)
    |=> (acc.addr == $past(regs.first_index_register) - 16'h0001);
  endproperty
  a_short_sext: assert property (p_short_sext) else $error("short disp not sign extended"); // RULE3

  property p_short_data;
    @(posedge sys_clk) disable iff (rst)
    (req.valid && req.mode == eag_pkg::EAG_SHORT_INDEX && !req.control && !bad_sel)
    |=> (acc.valid && acc.space == eag_pkg::EAG_SPACE_DATA);
  endproperty
  a_short_data: assert property (p_short_data) else $error("short index not data space"); // RULE4

  property p_pc_next;
    @(posedge sys_clk) disable iff (rst)
    (req.valid && req.mode == eag_pkg::EAG_PC_REL && !req.extended && !req.control)
    |=> (acc.addr == 16'($past(regs.next_pc) + $past(req.disp)) &&
         acc.space == eag_pkg::EAG_SPACE_PROG);
  endproperty
  a_pc_next: assert property (p_pc_next) else $error("pc relative base wrong"); // RULE6

  property p_pc_tmpl;
    @(posedge sys_clk) disable iff (rst)
    (req.valid && req.mode == eag_pkg::EAG_PC_REL && req.extended && !req.control)
    |=> (acc.addr == 16'($past(regs.template_pc) + $past(req.disp)));
  endproperty
  a_pc_tmpl: assert property (p_pc_tmpl) else $error("template base wrong"); // RULE7

  property p_jump;
    @(posedge sys_clk) disable iff (rst)
    (req.valid && req.control && req.mode == eag_pkg::EAG_PC_REL)
    |=> (pc_load && !acc.valid &&
         pc_target == 16'(($past(req.extended) ? $past(regs.template_pc) : $past(regs.next_pc))
                          + $past(req.disp)));
  endproperty
  a_jump: assert property (p_jump) else $error("relative jump not loaded"); // RULE9

  property p_sp_sel;
    @(posedge sys_clk) disable iff (rst)
    (req.valid && req.mode == eag_pkg::EAG_SP_REL && !req.control)
    |=> (acc.addr == 16'(($past(regs.user_mode) ? $past(regs.user_sp) : $past(regs.system_sp))
                         + $past(req.disp)));
  endproperty
  a_sp_sel: assert property (p_sp_sel) else $error("stack pointer select wrong"); // RULE11

  property p_bx_data;
    @(posedge sys_clk) disable iff (rst)
    (req.valid && req.mode == eag_pkg::EAG_BASE_INDEX && req.base_sel != req.index_sel
     && !req.control) |=> (acc.space == eag_pkg::EAG_SPACE_DATA);
  endproperty
  a_bx_data: assert property (p_bx_data) else $error("base index not data space"); // RULE13

  property p_word_hi;
    @(posedge sys_clk) disable iff (rst)
    acc.valid |-> (acc.addr_hi == 16'(acc.addr + 16'h0001));
  endproperty
  a_word_hi: assert property (p_word_hi) else $error("word high byte wrong"); // RULE14

  property p_epu_len;
    @(posedge sys_clk) disable iff (rst)
    (str_epu && str_len == 17'h00011) |=> str_len_error;
  endproperty
  a_epu_len: assert property (p_epu_len) else $error("epu string limit missed"); // RULE20

  property p_long_idx;
    @(posedge sys_clk) disable iff (rst)
    (req.valid && req.mode == eag_pkg::EAG_LONG_INDEX && !req.control &&
     req.index_sel == eag_pkg::EAG_SEL_SECOND)
    |=> (acc.valid && acc.addr == 16'($past(req.disp) + $past(regs.second_index_register)));
  endproperty
  a_long_idx: assert property (p_long_idx) else $error("long index address wrong"); // RULE1

  property p_short_idx;
    @(posedge sys_clk) disable iff (rst)
    (req.valid && req.mode == eag_pkg::EAG_SHORT_INDEX && !req.control &&
     req.index_sel == eag_pkg::EAG_SEL_SECOND)
    |=> (acc.valid && acc.addr == 16'($past(regs.second_index_register) +
                                      {{8{$past(req.disp[7])}}, $past(req.disp[7:0])}));
  endproperty
  a_short_idx: assert property (p_short_idx) else $error("short index address wrong"); // RULE2

  property p_short_pair;
    @(posedge sys_clk) disable iff (rst)
    (req.valid && req.mode == eag_pkg::EAG_SHORT_INDEX &&
     req.index_sel == eag_pkg::EAG_SEL_PAIR) |=> (sel_error && !acc.valid);
  endproperty
  a_short_pair: assert property (p_short_pair) else $error("short index pair select"); // RULE2

  property p_pc_space;
    @(posedge sys_clk) disable iff (rst)
    (req.valid && req.mode == eag_pkg::EAG_PC_REL && !req.control)
    |=> (acc.valid && acc.space == eag_pkg::EAG_SPACE_PROG);
  endproperty
  a_pc_space: assert property (p_pc_space) else $error("pc relative space wrong"); // RULE8

  property p_sp_data;
    @(posedge sys_clk) disable iff (rst)
    (req.valid && req.mode == eag_pkg::EAG_SP_REL && !req.control)
    |=> (acc.valid && acc.space == eag_pkg::EAG_SPACE_DATA);
  endproperty
  a_sp_data: assert property (p_sp_data) else $error("stack relative space wrong"); // RULE10

  property p_bx_same;
    @(posedge sys_clk) disable iff (rst)
    (req.valid && req.mode == eag_pkg::EAG_BASE_INDEX && req.base_sel == req.index_sel)
    |=> (sel_error && !acc.valid);
  endproperty
  a_bx_same: assert property (p_bx_same) else $error("same register accepted"); // RULE12

  property p_io_width;
    @(posedge sys_clk) disable iff (rst)
    (req.valid && req.mode == eag_pkg::EAG_LONG_INDEX && req.io_access && !req.control &&
     req.op_type == eag_pkg::EAG_OP_BYTE)
    |=> (acc.space == eag_pkg::EAG_SPACE_IO && acc.word == $past(req.io_word));
  endproperty
  a_io_width: assert property (p_io_width) else $error("io width or space wrong"); // RULE15

  property p_bit_sel;
    @(posedge sys_clk) disable iff (rst)
    (req.valid && req.op_type == eag_pkg::EAG_OP_BIT && !req.control && !bad_sel)
    |=> ($onehot(acc.bit_mask) && acc.bit_mask[$past(req.bit_num)]);
  endproperty
  a_bit_sel: assert property (p_bit_sel) else $error("bit mask wrong"); // RULE17

  property p_bcd;
    @(posedge sys_clk) disable iff (rst)
    (req.valid && req.op_type == eag_pkg::EAG_OP_BCD && !req.control && !bad_sel)
    |=> (acc.bcd && acc.bit_mask == 8'h00);
  endproperty
  a_bcd: assert property (p_bcd) else $error("packed decimal flag wrong"); // RULE18

  property p_str_max;
    @(posedge sys_clk) disable iff (rst)
    (!str_epu && str_len == 17'h10000) |=> !str_len_error;
  endproperty
  a_str_max: assert property (p_str_max) else $error("full length string refused"); // RULE19

  property p_jump_hold;
    @(posedge sys_clk) disable iff (rst)
    !pc_load |-> $stable(pc_target);
  endproperty
  a_jump_hold: assert property (p_jump_hold) else $error("jump target moved"); // RULE9
endmodule

// ---- testbench/eag_partner.sv ----
// memory access unit model that takes each generated access
module eag_partner (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire eag_pkg::eag_acc_type acc,
  output logic [15:0]               got_addr_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // each valid access latches addr into got_addr_q; addr_hi is never taken, even for a word
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      got_addr_q <= 16'h0000;
    end else if (acc.valid) begin
      got_addr_q <= acc.addr;
    end
  end
endmodule

// ---- testbench/effective_address_generator_tb.sv ----
// self-checking bench for the effective address generator
module effective_address_generator_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  sys_clk = 1'b0;
  logic                  rst = 1'b1;
  eag_pkg::eag_req_type  req;
  eag_pkg::eag_regs_type regs;
  logic [16:0]           str_len;
  logic                  str_epu;
  eag_pkg::eag_acc_type  acc;
  logic                  pc_load;
  logic [15:0]           pc_target;
  logic                  sel_error;
  logic                  str_len_error;
  logic [15:0]           got_addr;
  int                    miscompares = 0;
  int                    n_checks = 0;

  always #5 sys_clk = ~sys_clk;

  eag_top eag_top_inst (.sys_clk(sys_clk), .rst(rst), .req(req), .regs(regs),
    .str_len(str_len), .str_epu(str_epu), .acc(acc), .pc_load(pc_load),
    .pc_target(pc_target), .sel_error(sel_error), .str_len_error(str_len_error));
  eag_partner eag_partner_inst (.sys_clk(sys_clk), .rst(rst), .acc(acc),
    .got_addr_q(got_addr));

  task automatic report_and_stop;
    if (miscompares == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic eag_pkg::eag_req_type mk(eag_pkg::eag_mode_type m,
      eag_pkg::eag_reg_sel_type b, eag_pkg::eag_reg_sel_type i, logic [15:0] d);
    mk = '0;
    mk.mode = m;
    mk.base_sel = b;
    mk.index_sel = i;
    mk.disp = d;
  endfunction

  // one request, answer is settled on return
  task automatic go(input eag_pkg::eag_req_type r);
    @(posedge sys_clk);
    #1;
    r.valid = 1'b1;
    req = r;
    @(posedge sys_clk);
    #1;
    req.valid = 1'b0;
  endtask

  task automatic t_long;
    eag_pkg::eag_req_type r;
    regs.first_index_register = 16'h01fe;
    regs.second_index_register = 16'hfffe;
    go(mk(eag_pkg::EAG_LONG_INDEX, eag_pkg::EAG_SEL_PAIR, eag_pkg::EAG_SEL_FIRST, 16'h231a));
    chk(acc.valid, 1);
    chk(acc.addr, 16'h2518);
    go(mk(eag_pkg::EAG_LONG_INDEX, eag_pkg::EAG_SEL_PAIR, eag_pkg::EAG_SEL_SECOND, 16'h0010));
    chk(acc.addr, 16'h000e);
    r = mk(eag_pkg::EAG_LONG_INDEX, eag_pkg::EAG_SEL_PAIR, eag_pkg::EAG_SEL_FIRST, 16'h0000);
    r.io_access = 1'b1;
    r.io_word = 1'b1;
    go(r);
    chk(acc.space, eag_pkg::EAG_SPACE_IO);
    chk(acc.word, 1);
    r.io_word = 1'b0;
    go(r);
    chk({acc.space, acc.word}, {eag_pkg::EAG_SPACE_IO, 1'b0});
  endtask

  task automatic t_short;
    regs.first_index_register = 16'h203a;
    go(mk(eag_pkg::EAG_SHORT_INDEX, eag_pkg::EAG_SEL_PAIR, eag_pkg::EAG_SEL_FIRST, 16'h00ff));
    chk(acc.addr, 16'h2039);
    chk(acc.addr_hi, 16'h203a);
    chk(acc.space, eag_pkg::EAG_SPACE_DATA);
    regs.second_index_register = 16'h1000;
    go(mk(eag_pkg::EAG_SHORT_INDEX, eag_pkg::EAG_SEL_PAIR, eag_pkg::EAG_SEL_SECOND, 16'h7f7f));
    chk(acc.addr, 16'h107f);
    go(mk(eag_pkg::EAG_SHORT_INDEX, eag_pkg::EAG_SEL_PAIR, eag_pkg::EAG_SEL_PAIR, 16'h0001));
    chk({acc.valid, sel_error}, 2'b01);
  endtask

  task automatic t_pc;
    eag_pkg::eag_req_type r;
    regs.next_pc = 16'h1000;
    regs.template_pc = 16'h4000;
    r = mk(eag_pkg::EAG_PC_REL, eag_pkg::EAG_SEL_PAIR, eag_pkg::EAG_SEL_PAIR, 16'h0010);
    go(r);
    chk(acc.addr, 16'h1010);
    chk(acc.space, eag_pkg::EAG_SPACE_PROG);
    r.disp = 16'h8000;
    go(r);
    chk(acc.addr, 16'h9000);
    r.extended = 1'b1;
    go(r);
    chk(acc.addr, 16'hc000);
    r.extended = 1'b0;
    r.control = 1'b1;
    r.disp = 16'hfff0;
    go(r);
    chk({acc.valid, pc_load, pc_target}, {2'b01, 16'h0ff0});
    @(posedge sys_clk);
    #1;
    chk({pc_load, pc_target}, {1'b0, 16'h0ff0});
    r.extended = 1'b1;
    go(r);
    chk({acc.valid, pc_load, pc_target}, {2'b01, 16'h3ff0});
  endtask

  task automatic t_sp;
    regs.system_sp = 16'h8200;
    regs.user_sp = 16'hfff0;
    regs.user_mode = 1'b0;
    go(mk(eag_pkg::EAG_SP_REL, eag_pkg::EAG_SEL_PAIR, eag_pkg::EAG_SEL_PAIR, 16'h0002));
    chk(acc.addr, 16'h8202);
    chk(acc.space, eag_pkg::EAG_SPACE_DATA);
    regs.user_mode = 1'b1;
    go(mk(eag_pkg::EAG_SP_REL, eag_pkg::EAG_SEL_PAIR, eag_pkg::EAG_SEL_PAIR, 16'h0020));
    chk(acc.addr, 16'h0010);
  endtask

  task automatic t_bx;
    regs.pointer_pair_register = 16'h1234;
    regs.second_index_register = 16'h0100;
    go(mk(eag_pkg::EAG_BASE_INDEX, eag_pkg::EAG_SEL_PAIR, eag_pkg::EAG_SEL_SECOND, 16'h5555));
    chk(acc.addr, 16'h1334);
    chk(acc.space, eag_pkg::EAG_SPACE_DATA);
    go(mk(eag_pkg::EAG_BASE_INDEX, eag_pkg::EAG_SEL_FIRST, eag_pkg::EAG_SEL_FIRST, 16'h0000));
    chk({acc.valid, sel_error}, 2'b01);
    chk(got_addr, 16'h1334);
  endtask

  task automatic t_types;
    eag_pkg::eag_req_type r;
    r = mk(eag_pkg::EAG_LONG_INDEX, eag_pkg::EAG_SEL_PAIR, eag_pkg::EAG_SEL_FIRST, 16'h0000);
    r.op_type = eag_pkg::EAG_OP_BIT;
    for (int n = 0; n < 8; n++) begin
      r.bit_num = 3'(n);
      r.bit_op = eag_pkg::eag_bitop_type'(2'(n % 3));
      go(r);
      chk(acc.bit_mask, 8'h01 << n);
      chk(acc.bit_op, n % 3);
    end
    r.op_type = eag_pkg::EAG_OP_BCD;
    go(r);
    chk({acc.bcd, acc.bit_mask}, 9'h100);
    r.op_type = eag_pkg::EAG_OP_WORD;
    go(r);
    chk(acc.word, 1);
  endtask

  // length limit checked one cycle after the length is presented
  task automatic t_str;
    logic [16:0] lens [5] = '{17'h10000, 17'h10001, 17'h00000, 17'h00010, 17'h00011};
    logic        epus [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    logic        errs [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    for (int k = 0; k < 5; k++) begin
      @(posedge sys_clk);
      #1;
      str_len = lens[k];
      str_epu = epus[k];
      @(posedge sys_clk);
      #1;
      chk(str_len_error, errs[k]);
    end
  endtask

  initial begin
    #100000;
    miscompares++;
    report_and_stop();
  end

  initial begin
    req = '0;
    regs = '0;
    str_len = 17'h00001;
    str_epu = 1'b0;
    repeat (12) @(posedge sys_clk);
    #1;
    chk(acc.valid, 0);
    rst = 1'b0;
    t_long();
    t_short();
    t_pc();
    t_sp();
    t_bx();
    t_types();
    t_str();
    report_and_stop();
  end
endmodule
